// ===== rtl/ioxp_expander.sv
// Sixteen-pin serial-bus I/O expander, device side
// Notes on behaviour
// - Sixteen pins in two byte banks, each with direction, input, output, polarity.
// - After reset every pin is an input with its driver off.
// - Master writes direction bits; each pin then follows its direction bit.
// - Input register holds pin values; output register holds driven values.
// - Set polarity bit reports that pin inverted in the input register.
// - Every register reads back its present contents over the bus.
// - Reset returns all registers to defaults and restarts the slave machine.
// - Low reset input performs the same initialisation as power-on.
// - Alert asserts while any input pin differs from the value last read from its bank.
// - Alert output is open drain, active low, released otherwise.
// - One strap pin supplies the lowest slave address bit.
// - Slave works at bus clocks up to fast-mode rate.
// - Short glitches on clock and data lines are filtered out.
`timescale 1ns/1ps
`include "ioxp_defs.svh"
module ioxp_expander #(
   parameter logic [5:0] BASE_ADDR = `IOXP_BASE_ADDR,
   parameter int         FILT_CYC  = `IOXP_FILT_CYC
) (
   input  wire logic              REF_CLK,
   input  wire logic              RST_B,
   input  wire logic              SCL,
   input  wire logic              SDA_IN,
   output logic                   SDA_OUT,
   output logic                   SDA_OE,
   input  wire logic              ADDR_SEL,
   input  wire ioxp_pkg::ioxp_pins_type P_IN,
   output ioxp_pkg::ioxp_pins_type P_OUT,
   output ioxp_pkg::ioxp_pins_type P_OE,
   output logic                   ALERT_OUT,
   output logic                   ALERT_OE
);
   import ioxp_pkg::*;

   ioxp_line_if line ();

   // Sync and filter delay put each SDA answer about six clocks after SCL falls;
   // a master whose SCL low phase is shorter would see SDA move while SCL is high
   ioxp_line_filter #(
      .FILT_CYC (FILT_CYC)
   ) u_filt (
      .clk     (REF_CLK),
      .rst_b   (RST_B),
      .scl_pin (SCL),
      .sda_pin (SDA_IN),
      .line    (line.filt)
   );

   ioxp_state_type state_reg;
   ioxp_state_type state_next;
   ioxp_pins_type  pin_meta_reg;
   ioxp_pins_type  pin_sync_reg;
   ioxp_pins_type  out_reg;
   ioxp_pins_type  out_next;
   ioxp_pins_type  pol_reg;
   ioxp_pins_type  pol_next;
   ioxp_pins_type  cfg_reg;
   ioxp_pins_type  cfg_next;
   ioxp_pins_type  snap_reg;
   ioxp_pins_type  snap_next;
   logic           addr_meta_reg;
   logic           addr_sync_reg;
   logic           init_reg;
   logic [3:0]     bit_cnt_reg;
   logic [3:0]     bit_cnt_next;
   logic [7:0]     shift_reg;
   logic [7:0]     shift_next;
   logic [7:0]     tx_reg;
   logic [7:0]     tx_next;
   logic [2:0]     ptr_reg;
   logic [2:0]     ptr_next;
   logic           rw_reg;
   logic           rw_next;
   logic           nack_reg;
   logic           nack_next;
   logic           sda_low_reg;
   logic           sda_low_next;
   logic           alert_reg;
   logic           wr_en;
   logic           load_tx;

   // Decode and selection
   wire ioxp_pins_type live_in  = pin_sync_reg ^ pol_reg;
   wire [6:0]          own_addr = {BASE_ADDR, addr_sync_reg};
   wire                addr_hit = shift_reg[7:1] == own_addr;
   wire                bit_done = bit_cnt_reg == 4'h8;
   wire [2:0]          ptr_inc  = {ptr_reg[2:1], ~ptr_reg[0]};
   wire [2:0]          rd_ptr   = (state_reg == ST_RACK) ? ptr_inc : ptr_reg;
   wire                rd_bank  = rd_ptr[0];
   wire                rd_in    = rd_ptr[2:1] == `IOXP_GRP_IN;
   wire ioxp_pins_type rd_word  = (rd_ptr[2:1] == `IOXP_GRP_IN)  ? snap_next_src() :
                                  (rd_ptr[2:1] == `IOXP_GRP_OUT) ? out_reg :
                                  (rd_ptr[2:1] == `IOXP_GRP_POL) ? pol_reg : cfg_reg;
   wire [7:0]          rd_data  = rd_bank ? rd_word[15:8] : rd_word[7:0];
   // Output-direction pins never raise the alert
   wire ioxp_pins_type diff     = (live_in ^ snap_reg) & cfg_reg;
   wire                wr_bank  = ptr_reg[0];

   // Reading an input bank returns the live value, which also becomes the snapshot
   function automatic ioxp_pins_type snap_next_src();
      snap_next_src = live_in;
   endfunction : snap_next_src

   // Serial slave sequencing
   always_comb begin
      state_next   = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next   = shift_reg;
      tx_next      = tx_reg;
      ptr_next     = ptr_reg;
      rw_next      = rw_reg;
      nack_next    = nack_reg;
      sda_low_next = sda_low_reg;
      wr_en        = 1'b0;
      load_tx      = 1'b0;
      if (line.stop) begin
         state_next   = ST_IDLE;
         sda_low_next = 1'b0;
      end else if (line.start) begin
         state_next   = ST_ADDR;
         bit_cnt_next = 4'h0;
         sda_low_next = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_CMD, ST_WDAT: begin
               if (line.scl_rise) begin
                  shift_next   = {shift_reg[6:0], line.sda_lvl};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (line.scl_fall && bit_done) begin
                  bit_cnt_next = 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (addr_hit) begin
                        state_next   = ST_AACK;
                        sda_low_next = 1'b1;
                        rw_next      = shift_reg[0];
                     end else begin
                        state_next = ST_IDLE;
                     end
                  end else if (state_reg == ST_CMD) begin
                     ptr_next     = shift_reg[2:0];
                     state_next   = ST_CACK;
                     sda_low_next = 1'b1;
                  end else begin
                     wr_en        = 1'b1;
                     state_next   = ST_WACK;
                     sda_low_next = 1'b1;
                  end
               end
            end
            ST_AACK, ST_CACK, ST_WACK: begin
               if (line.scl_fall) begin
                  sda_low_next = 1'b0;
                  if (state_reg == ST_CACK) begin
                     state_next = ST_WDAT;
                  end else if (state_reg == ST_WACK) begin
                     state_next = ST_WDAT;
                     ptr_next   = ptr_inc;
                  end else if (rw_reg) begin
                     state_next   = ST_RDAT;
                     load_tx      = 1'b1;
                     tx_next      = rd_data;
                     sda_low_next = ~rd_data[7];
                  end else begin
                     state_next = ST_CMD;
                  end
               end
            end
            ST_RDAT: begin
               if (line.scl_rise) begin
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (line.scl_fall) begin
                  if (bit_done) begin
                     bit_cnt_next = 4'h0;
                     sda_low_next = 1'b0;
                     state_next   = ST_RACK;
                  end else begin
                     tx_next      = {tx_reg[6:0], 1'b0};
                     sda_low_next = ~tx_reg[6];
                  end
               end
            end
            ST_RACK: begin
               if (line.scl_rise) begin
                  nack_next = line.sda_lvl;
               end else if (line.scl_fall) begin
                  if (nack_reg) begin
                     state_next = ST_IDLE;
                  end else begin
                     ptr_next     = rd_ptr;
                     state_next   = ST_RDAT;
                     load_tx      = 1'b1;
                     tx_next      = rd_data;
                     sda_low_next = ~rd_data[7];
                  end
               end
            end
            ST_IDLE: begin
               sda_low_next = 1'b0;
            end
            default: begin
               state_next   = ST_IDLE;
               sda_low_next = 1'b0;
            end
         endcase
      end
   end

   // Register writes and input snapshot
   always_comb begin
      out_next  = out_reg;
      pol_next  = pol_reg;
      cfg_next  = cfg_reg;
      snap_next = snap_reg;
      if (wr_en) begin
         case (ptr_reg[2:1])
            `IOXP_GRP_OUT: out_next[wr_bank*8 +: 8] = shift_reg;
            `IOXP_GRP_POL: pol_next[wr_bank*8 +: 8] = shift_reg;
            `IOXP_GRP_CFG: cfg_next[wr_bank*8 +: 8] = shift_reg;
            default: begin
               out_next = out_reg;
            end
         endcase
      end
      // First cycle after reset adopts the pins so no alert comes from power-up
      if (!init_reg) begin
         snap_next = live_in;
      end else if (load_tx && rd_in) begin
         snap_next[rd_bank*8 +: 8] = live_in[rd_bank*8 +: 8];
      end
   end

   // Slave machine state; reset also restarts it
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         ptr_reg     <= 3'h0;
         rw_reg      <= 1'b0;
         nack_reg    <= 1'b1;
         sda_low_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
         tx_reg      <= tx_next;
         ptr_reg     <= ptr_next;
         rw_reg      <= rw_next;
         nack_reg    <= nack_next;
         sda_low_reg <= sda_low_next;
      end
   end

   // Port registers, defaults while RST_B is low
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         out_reg  <= `IOXP_OUT_RST;
         pol_reg  <= `IOXP_POL_RST;
         cfg_reg  <= `IOXP_CFG_RST;
         snap_reg <= `IOXP_SNAP_RST;
         init_reg <= 1'b0;
      end else begin
         out_reg  <= out_next;
         pol_reg  <= pol_next;
         cfg_reg  <= cfg_next;
         snap_reg <= snap_next;
         init_reg <= 1'b1;
      end
   end

   // Pins and strap cross in from outside
   // Not reset: the first snapshot after release needs real pin levels
   always_ff @(posedge REF_CLK) begin
      pin_meta_reg  <= P_IN;
      pin_sync_reg  <= pin_meta_reg;
      addr_meta_reg <= ADDR_SEL;
      addr_sync_reg <= addr_meta_reg;
   end

   // Alert raised one cycle after a difference shows
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= init_reg && (|diff);
      end
   end

   // Outputs: a zero bit in direction enables that pin's driver
   assign P_OUT     = out_reg;
   assign P_OE      = ~cfg_reg;
   assign SDA_OUT   = 1'b0;
   assign SDA_OE    = sda_low_reg;
   assign ALERT_OUT = 1'b0;
   assign ALERT_OE  = alert_reg;
endmodule : ioxp_expander

// ===== rtl/ioxp_defs.svh
// Constants for the sixteen-pin serial I/O expander
`ifndef IOXP_DEFS_SVH
`define IOXP_DEFS_SVH
`define IOXP_NPINS       16
`define IOXP_BANK_W      8
`define IOXP_GRP_IN      2'h0
`define IOXP_GRP_OUT     2'h1
`define IOXP_GRP_POL     2'h2
`define IOXP_GRP_CFG     2'h3
`define IOXP_OUT_RST     16'hffff
`define IOXP_POL_RST     16'h0000
`define IOXP_CFG_RST     16'hffff
`define IOXP_SNAP_RST    16'h0000
`define IOXP_BASE_ADDR   6'h10
`define IOXP_CLK_NS      40
`define IOXP_FILT_NS     50
`define IOXP_FILT_CYC    ((`IOXP_FILT_NS + `IOXP_CLK_NS - 1) / `IOXP_CLK_NS)
`define IOXP_SCL_MAX_KHZ 400
`endif

// ===== rtl/ioxp_pkg.sv
// Types shared by the expander modules
`include "ioxp_defs.svh"
package ioxp_pkg;
   typedef logic [`IOXP_NPINS-1:0] ioxp_pins_type;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_AACK = 4'h3,
      ST_CMD  = 4'h2,
      ST_CACK = 4'h6,
      ST_WDAT = 4'h7,
      ST_WACK = 4'h5,
      ST_RDAT = 4'h4,
      ST_RACK = 4'hc
   } ioxp_state_type;
endpackage : ioxp_pkg

// ===== rtl/ioxp_line_if.sv
// Filtered serial line events passed from the filter to the slave core
`timescale 1ns/1ps
interface ioxp_line_if;
   logic sda_lvl;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport filt (output sda_lvl, output scl_rise, output scl_fall, output start, output stop);
   modport core (input sda_lvl, input scl_rise, input scl_fall, input start, input stop);
endinterface : ioxp_line_if

// ===== rtl/ioxp_line_filter.sv
// Synchroniser, glitch filter and edge/condition detection for the serial lines
`timescale 1ns/1ps
`include "ioxp_defs.svh"
module ioxp_line_filter #(
   parameter int FILT_CYC = `IOXP_FILT_CYC
) (
   input  wire logic  clk,
   input  wire logic  rst_b,
   input  wire logic  scl_pin,
   input  wire logic  sda_pin,
   ioxp_line_if.filt  line
);
   localparam logic [3:0] FILT_C = 4'(FILT_CYC);

   wire  [1:0] raw = {sda_pin, scl_pin};
   wire  [1:0] filt;
   logic       scl_prev_reg;
   logic       sda_prev_reg;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_line
         logic       meta_reg;
         logic       sync_reg;
         logic       lvl_reg;
         logic [3:0] cnt_reg;
         // Level must hold FILT_CYC+1 samples before it is believed
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               meta_reg <= 1'b1;
               sync_reg <= 1'b1;
               lvl_reg  <= 1'b1;
               cnt_reg  <= 4'h0;
            end else begin
               meta_reg <= raw[i];
               sync_reg <= meta_reg;
               if (sync_reg == lvl_reg) begin
                  cnt_reg <= 4'h0;
               end else if (cnt_reg == FILT_C) begin
                  lvl_reg <= sync_reg;
                  cnt_reg <= 4'h0;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
         end
         assign filt[i] = lvl_reg;
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= filt[0];
         sda_prev_reg <= filt[1];
      end
   end

   assign line.sda_lvl  = filt[1];
   assign line.scl_rise = filt[0] & ~scl_prev_reg;
   assign line.scl_fall = ~filt[0] & scl_prev_reg;
   assign line.start    = filt[0] & scl_prev_reg & sda_prev_reg & ~filt[1];
   assign line.stop     = filt[0] & scl_prev_reg & ~sda_prev_reg & filt[1];
endmodule : ioxp_line_filter

// ===== verification/ioxp_bus_master.sv
// Serial bus master model for the expander's clock and data lines
`timescale 1ns/1ps
module ioxp_bus_master (
   input  wire logic clk,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Low phase outlasts the slave's answer delay, so SDA only moves while SCL is low
   task automatic bit_io(input logic b, output logic s);
      tick(2);
      sda_drv = b;
      tick(6);
      scl = 1'b1;
      tick(4);
      s = sda_in;
      scl = 1'b0;
   endtask : bit_io
   // Serves as start and repeated start
   task automatic start_c;
      tick(2);
      sda_drv = 1'b1;
      tick(6);
      scl = 1'b1;
      tick(4);
      sda_drv = 1'b0;
      tick(4);
      scl = 1'b0;
   endtask : start_c
   task automatic stop_c;
      tick(2);
      sda_drv = 1'b0;
      tick(6);
      scl = 1'b1;
      tick(4);
      sda_drv = 1'b1;
      tick(4);
   endtask : stop_c
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : put_byte
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, s);
   endtask : get_byte
endmodule : ioxp_bus_master

// ===== verification/ioxp_expander_checker.sv
// Port-level assertions for the expander
`timescale 1ns/1ps
module ioxp_expander_checker (
   input wire logic                    REF_CLK,
   input wire logic                    RST_B,
   input wire logic                    SCL,
   input wire logic                    SDA_OUT,
   input wire logic                    SDA_OE,
   input wire ioxp_pkg::ioxp_pins_type P_IN,
   input wire ioxp_pkg::ioxp_pins_type P_OUT,
   input wire ioxp_pkg::ioxp_pins_type P_OE,
   input wire logic                    ALERT_OUT,
   input wire logic                    ALERT_OE
);
   logic [15:0] pin_reg;
   logic        scl_reg;
   logic [4:0]  hi_reg, fall_reg, quiet_reg;
   logic [4:0]  hi_next, fall_next, quiet_next;
   function automatic logic [4:0] sat(input logic [4:0] v);
      return v + {4'h0, v != 5'h1f};
   endfunction : sat
   assign hi_next = SCL ? sat(hi_reg) : 5'h00;
   assign fall_next = (scl_reg && !SCL) ? 5'h00 : sat(fall_reg);
   // SCL low or any pin change restarts the quiet count
   assign quiet_next = (!SCL || P_IN != pin_reg) ? 5'h00 : sat(quiet_reg);
   always_ff @(posedge REF_CLK) begin
      pin_reg <= P_IN;
      scl_reg <= SCL;
      hi_reg <= RST_B ? hi_next : 5'h00;
      fall_reg <= RST_B ? fall_next : 5'h1f;
      quiet_reg <= RST_B ? quiet_next : 5'h00;
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   sequence s_rst_rel;
      $rose(RST_B);
   endsequence
   reset_defaults_a: assert property (disable iff (1'b0) !RST_B |=>
      P_OE == 16'h0000 && P_OUT == 16'hffff && !ALERT_OE && !SDA_OE) else $error("reset values");
   sda_open_drain_a: assert property (SDA_OUT == 1'b0) else $error("data driven high");
   alert_open_drain_a: assert property (ALERT_OUT == 1'b0) else $error("alert high");
   alert_quiet_a: assert property (quiet_reg >= 5'd10 |-> $stable(ALERT_OE))
      else $error("alert moved without cause");
   alert_release_a: assert property (s_rst_rel |-> !ALERT_OE [*3])
      else $error("alert after reset");
   pins_after_fall_a: assert property ($changed(P_OUT) || $changed(P_OE) |->
      fall_reg inside {[5'd2:5'd12]}) else $error("pins changed off clock fall");
   sda_idle_a: assert property (hi_reg >= 5'd12 |-> !SDA_OE) else $error("data held idle");
   sda_after_fall_a: assert property ($changed(SDA_OE) |-> fall_reg inside {[5'd2:5'd12]})
      else $error("data moved off clock fall");
endmodule : ioxp_expander_checker
bind ioxp_expander ioxp_expander_checker chk_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .SCL(SCL),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .P_IN(P_IN), .P_OUT(P_OUT), .P_OE(P_OE),
   .ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE));

// ===== verification/ioxp_expander_test.sv
// Self-checking bench for the serial I/O expander
`timescale 1ns/1ps
`include "ioxp_defs.svh"
module ioxp_expander_test;
   import ioxp_pkg::*;
   logic          ref_clk, rst_b, addr_sel;
   logic [15:0]   pin_drv;
   logic [7:0]    m [8];
   int            num_errors, n_checks;
   wire           scl, sda_drv, sda, sda_out, sda_oe, alert_out, alert_oe, alert_n;
   ioxp_pins_type p_in, p_out, p_oe;
   wire [15:0]    cfg16 = {m[7], m[6]};
   wire [15:0]    pin_mdl = (~cfg16 & {m[3], m[2]}) | (cfg16 & pin_drv);
   wire [6:0]     dev_addr = {`IOXP_BASE_ADDR, addr_sel};
   // Wired lines with pull-ups; output pins carry the latched level
   assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
   assign alert_n = alert_oe ? alert_out : 1'b1;
   assign p_in = (p_oe & p_out) | (~p_oe & pin_drv);
   ioxp_bus_master bm (.clk(ref_clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
   ioxp_expander uut (.REF_CLK(ref_clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel), .P_IN(p_in), .P_OUT(p_out),
      .P_OE(p_oe), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("errors=%0d checks=%0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic do_reset;
      rst_b = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      m = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
      repeat (12) @(posedge ref_clk);
      #1;
      chk(p_oe, 16'h0000);
      chk(p_out, `IOXP_OUT_RST);
      chk(alert_n, 1'b1);
   endtask : do_reset
   task automatic wr(input logic [6:0] a, input logic [2:0] c, input logic [7:0] q[$]);
      logic ak;
      bm.start_c();
      bm.put_byte({a, 1'b0}, ak);
      chk(ak, a == dev_addr);
      if (a == dev_addr) begin
         bm.put_byte({5'h00, c}, ak);
         foreach (q[i]) begin
            bm.put_byte(q[i], ak);
            chk(ak, 1'b1);
            if (c > 3'h1) m[c] = q[i];
            c[0] = ~c[0];
         end
      end
      bm.stop_c();
      chk(p_out, {m[3], m[2]});
      chk(p_oe, ~cfg16);
   endtask : wr
   task automatic rd(input logic [2:0] c, input int n);
      logic ak;
      logic [7:0] d;
      logic [15:0] in16;
      bm.start_c();
      bm.put_byte({dev_addr, 1'b0}, ak);
      bm.put_byte({5'h00, c}, ak);
      bm.start_c();
      bm.put_byte({dev_addr, 1'b1}, ak);
      for (int i = 0; i < n; i++) begin
         in16 = pin_mdl ^ {m[5], m[4]};
         bm.get_byte(i == n - 1, d);
         chk(d, c < 3'h2 ? in16[c[0]*8 +: 8] : m[c]);
         c[0] = ~c[0];
      end
      bm.stop_c();
   endtask : rd
   task automatic pin_flip(input logic [15:0] f, input logic exp);
      pin_drv = pin_drv ^ f;
      repeat (10) @(posedge ref_clk);
      #1;
      chk(alert_n, exp);
   endtask : pin_flip
   initial begin
      rst_b = 1'b0;
      addr_sel = 1'b0;
      pin_drv = 16'h0000;
      num_errors = 0;
      n_checks = 0;
      m = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
      void'($urandom(21));
      do_reset();
      for (int c = 0; c < 8; c += 2) rd(3'(c), 2);
      for (int r = 0; r < 3; r++) begin
         pin_drv = 16'($urandom());
         wr(dev_addr, 3'h2, '{8'($urandom()), 8'($urandom())});
         wr(dev_addr, 3'h5, '{8'($urandom()), 8'($urandom())});
         wr(dev_addr, 3'h6, '{8'($urandom()), 8'($urandom())});
         wr(dev_addr, 3'h0, '{8'($urandom())});
         rd(3'h0, 2);
         rd(3'h3, 2);
         rd(3'h4, 2);
         rd(3'h7, 2);
      end
      wr(dev_addr, 3'h6, '{8'hf0, 8'h0f});
      rd(3'h0, 2);
      chk(alert_n, 1'b1);
      pin_flip(16'h0010, 1'b0);
      pin_flip(16'h0010, 1'b1);
      pin_flip(16'h0100, 1'b0);
      rd(3'h1, 1);
      chk(alert_n, 1'b1);
      for (int s = 0; s < 2; s++) begin
         addr_sel = s[0];
         wr(dev_addr ^ 7'h01, 3'h2, '{8'h00});
         wr(dev_addr, 3'h2, '{8'(8'ha5 ^ s)});
      end
      do_reset();
      rd(3'h6, 2);
      test_done();
   end
   initial begin
      #(40 * 60000);
      num_errors++;
      test_done();
   end
endmodule : ioxp_expander_test
